/* rtl/rxfq_addr_calc.sv */
// physical address of one queue element: base plus dword index
module rxfq_addr_calc (
  // operands
  input wire logic [rxfq_pkg::DATA_W-1:0] base_i,
  input wire logic [rxfq_pkg::IDX_W-1:0] index_i,
  // result
  output logic [rxfq_pkg::DATA_W-1:0] addr_o
);

  // index lands on bits 17..2; carry out of bit 31 wraps by design
  always_comb begin
    addr_o = base_i + {14'h0000, index_i, 2'h0};
  end

endmodule

/* rtl/rxfq_ptr_regs.sv */
// Functional notes
// RULE1: large write address is base plus index times four
// RULE2: large read address is base plus index times four
// RULE3: large end address is base plus index times four
// RULE4: small start address is base plus index times four
// RULE5: host initialises all pointers before queue use
// RULE6: host spaces same-register writes four clocks apart
// RULE7: index in low half, upper half unused
// RULE8: small write address is base plus index times four
// RULE9: host writes base dword aligned
// RULE10: base low half held until high half written
// RULE11: write updates all bits; no enables, no access
// RULE12: pointers reset to zero, upper writes ignored
module rxfq_ptr_regs (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // host register port
  input wire rxfq_pkg::rxfq_req_t req_i,
  output logic [rxfq_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  // to the transfer engine
  output logic [rxfq_pkg::DATA_W-1:0] queue_base_o,
  output rxfq_pkg::rxfq_addr_vec_t queue_addr_o
);

  typedef struct packed {
    logic [rxfq_pkg::DATA_W-1:0] base;
    logic [rxfq_pkg::IDX_W-1:0] base_lo_hold;
    logic [rxfq_pkg::PTR_NUM-1:0][rxfq_pkg::IDX_W-1:0] ptr;
    rxfq_pkg::rxfq_addr_vec_t phys;
    logic [rxfq_pkg::DATA_W-1:0] rdata;
    logic rvalid;
  } rxfq_state_t;

  rxfq_state_t st_q;
  rxfq_state_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic access;
  rxfq_pkg::rxfq_addr_vec_t phys_calc;

  // reset release through two flops, assert stays asynchronous
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // byte enables do not select lanes; all negated means no access
  assign access = (req_i.be_n != rxfq_pkg::BE_NONE_N); // RULE11

  // one adder per pointer against the shared base
  for (genvar i = 0; i < rxfq_pkg::PTR_NUM; i++) begin : g_addr
    rxfq_addr_calc u_calc (
      .base_i(st_q.base),
      .index_i(st_q.ptr[i]),
      .addr_o(phys_calc[i])
    );
  end

  // register writes, reads and address refresh
  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    // addresses lag a write by two cycles, one behind the registers; engine must not sample mid-update
    st_d.phys = phys_calc; // RULE1 RULE2 RULE3 RULE4 RULE8
    if (req_i.wr && access) begin
      if (req_i.addr == rxfq_pkg::BASE_LO_OFS) begin
        st_d.base_lo_hold = req_i.wdata[15:0]; // RULE10
      end
      if (req_i.addr == rxfq_pkg::BASE_HI_OFS) begin
        st_d.base = {req_i.wdata[15:0], st_q.base_lo_hold}; // RULE10
      end
      for (int i = 0; i < rxfq_pkg::PTR_NUM; i++) begin
        if (req_i.addr == rxfq_pkg::PTR_OFS[i]) begin
          st_d.ptr[i] = req_i.wdata[15:0]; // RULE11 RULE12
        end
      end
    end
    if (req_i.rd && access) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = rxfq_pkg::RD_ZERO;
      if (req_i.addr == rxfq_pkg::BASE_LO_OFS) begin
        st_d.rdata[15:0] = st_q.base_lo_hold;
      end
      if (req_i.addr == rxfq_pkg::BASE_HI_OFS) begin
        st_d.rdata[15:0] = st_q.base[31:16];
      end
      for (int i = 0; i < rxfq_pkg::PTR_NUM; i++) begin
        if (req_i.addr == rxfq_pkg::PTR_OFS[i]) begin
          st_d.rdata[15:0] = st_q.ptr[i]; // RULE7
        end
      end
    end
  end

  // state register, everything cleared at reset
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q.base <= rxfq_pkg::BASE_RST;
      st_q.base_lo_hold <= rxfq_pkg::IDX_RST;
      st_q.ptr <= '0; // RULE12
      st_q.phys <= '0;
      st_q.rdata <= rxfq_pkg::RD_ZERO;
      st_q.rvalid <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data_o = st_q.rdata;
  assign rd_valid_o = st_q.rvalid;
  assign queue_base_o = st_q.base;
  assign queue_addr_o = st_q.phys;

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  property p_large_write_addr;
    ##1 queue_addr_o[0] == $past(st_q.base) + {14'h0000, $past(st_q.ptr[0]), 2'h0};
  endproperty
  a_large_write_addr: assert property (p_large_write_addr) else $error("large write address wrong"); // RULE1

  property p_large_read_addr;
    (req_i.wr && access && req_i.addr == rxfq_pkg::PTR_OFS[1])
      |-> ##2 queue_addr_o[1][17:0] == $past(st_q.base[17:0]) + {$past(req_i.wdata[15:0], 2), 2'h0};
  endproperty
  a_large_read_addr: assert property (p_large_read_addr) else $error("large read address wrong"); // RULE2

  property p_large_end_addr;
    // addresses lag the registers by one edge, so compare against last cycle's operands
    $stable(st_q.base) && $stable(st_q.ptr[2])
      |=> queue_addr_o[2] - $past(st_q.base) == {14'h0000, $past(st_q.ptr[2]), 2'h0};
  endproperty
  a_large_end_addr: assert property (p_large_end_addr) else $error("large end address wrong"); // RULE3

  property p_small_start_addr;
    ##1 queue_addr_o[3][1:0] == $past(st_q.base[1:0]) &&
      queue_addr_o[3] == $past(st_q.base) + {14'h0000, $past(st_q.ptr[3]), 2'h0};
  endproperty
  a_small_start_addr: assert property (p_small_start_addr) else $error("small start address wrong"); // RULE4

  property p_small_write_addr;
    ##1 queue_addr_o[4] == $past(st_q.base) + {14'h0000, $past(st_q.ptr[4]), 2'h0};
  endproperty
  a_small_write_addr: assert property (p_small_write_addr) else $error("small write address wrong"); // RULE8

  property p_upper_half_zero;
    rd_valid_o |-> rd_data_o[31:16] == 16'h0000;
  endproperty
  a_upper_half_zero: assert property (p_upper_half_zero) else $error("upper read half not zero"); // RULE7

  property p_base_held;
    (req_i.wr && access && req_i.addr == rxfq_pkg::BASE_LO_OFS) |=> $stable(queue_base_o);
  endproperty
  a_base_held: assert property (p_base_held) else $error("base changed on low half write"); // RULE10

  property p_base_commit;
    (req_i.wr && access && req_i.addr == rxfq_pkg::BASE_HI_OFS)
      |=> queue_base_o == {$past(req_i.wdata[15:0]), $past(st_q.base_lo_hold)};
  endproperty
  a_base_commit: assert property (p_base_commit) else $error("base not committed"); // RULE10

  property p_no_enable_no_write;
    (req_i.wr && req_i.be_n == rxfq_pkg::BE_NONE_N) |=> $stable(st_q.ptr) && $stable(st_q.base) && !rd_valid_o;
  endproperty
  a_no_enable_no_write: assert property (p_no_enable_no_write) else $error("access with no enables"); // RULE11

  property p_ptr_write_full;
    (req_i.wr && access && req_i.addr == rxfq_pkg::PTR_OFS[0]) |=> st_q.ptr[0] == $past(req_i.wdata[15:0]);
  endproperty
  a_ptr_write_full: assert property (p_ptr_write_full) else $error("pointer write not taken"); // RULE11

  property p_reset_zero;
    @(posedge mclk_i) disable iff (1'b0) $rose(rst_n) |-> st_q.ptr == '0 && queue_addr_o == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("pointers not zero after reset"); // RULE12

  // a taken read always answers in the next cycle
  property p_read_latency;
    (req_i.rd && access) |=> rd_valid_o;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read not answered"); // RULE11

  // no stray valid pulses without a taken read
  property p_rvalid_pulse;
    !(req_i.rd && access) |=> !rd_valid_o;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read"); // RULE11

  // read of a pointer returns the old index in the low half
  property p_read_ptr_data;
    (req_i.rd && access && req_i.addr == rxfq_pkg::PTR_OFS[2])
      |=> rd_data_o == {16'h0000, $past(st_q.ptr[2])};
  endproperty
  a_read_ptr_data: assert property (p_read_ptr_data) else $error("pointer read data wrong"); // RULE7

  // high base half reads the committed base
  property p_read_base_hi;
    (req_i.rd && access && req_i.addr == rxfq_pkg::BASE_HI_OFS)
      |=> rd_data_o == {16'h0000, $past(st_q.base[31:16])};
  endproperty
  a_read_base_hi: assert property (p_read_base_hi) else $error("base high read wrong"); // RULE7

  // low base half reads the holding register, not the live base
  property p_read_hold;
    (req_i.rd && access && req_i.addr == rxfq_pkg::BASE_LO_OFS)
      |=> rd_data_o == {16'h0000, $past(st_q.base_lo_hold)};
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("base low read wrong"); // RULE10

  // pointers only move on a taken write
  property p_ptr_idle;
    !(req_i.wr && access) |=> $stable(st_q.ptr);
  endproperty
  a_ptr_idle: assert property (p_ptr_idle) else $error("pointer changed without write"); // RULE11

  c_base_update: cover property ((req_i.wr && req_i.addr == rxfq_pkg::BASE_LO_OFS) ##[1:8]
    (req_i.wr && req_i.addr == rxfq_pkg::BASE_HI_OFS));
  c_ptr_read: cover property (req_i.rd && access && req_i.addr == rxfq_pkg::PTR_OFS[4]);
  c_dead_write: cover property (req_i.wr && !access);
  // high base plus top index wraps past bit 31
  c_addr_wrap: cover property (queue_addr_o[4] < queue_base_o);
  c_reset_release: cover property ($rose(rst_n));

endmodule

/* shared/rxfq_pkg.sv */
package rxfq_pkg;

  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  localparam int PTR_NUM = 5;
  // index field gives address bits 17 to 2
  localparam int IDX_SHIFT = 2;

  // pointer slots, also the loop index
  localparam int LARGE_WRITE = 0;
  localparam int LARGE_READ = 1;
  localparam int LARGE_END = 2;
  localparam int SMALL_START = 3;
  localparam int SMALL_WRITE = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] BASE_LO_OFS = 12'h290;
  localparam logic [ADDR_W-1:0] BASE_HI_OFS = 12'h294;
  localparam logic [PTR_NUM-1:0][ADDR_W-1:0] PTR_OFS = {12'h2ac, 12'h2a8, 12'h2a4, 12'h2a0, 12'h29c};

  // reset values
  localparam logic [IDX_W-1:0] IDX_RST = 16'h0000;
  localparam logic [DATA_W-1:0] BASE_RST = 32'h0000_0000;
  // unused upper half and unmapped reads return this
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  // all four enables negated (active low)
  localparam logic [3:0] BE_NONE_N = 4'hf;

  // host register access, one cycle per request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be_n;
    logic [DATA_W-1:0] wdata;
  } rxfq_req_t;

  typedef logic [PTR_NUM-1:0][DATA_W-1:0] rxfq_addr_vec_t;

endpackage

/* test/rxfq_host.sv */
// host software issuing register accesses over the system bus
module rxfq_host (
  // clock
  input wire logic mclk_i,
  // register port
  output rxfq_pkg::rxfq_req_t req_o,
  input wire logic [rxfq_pkg::DATA_W-1:0] rd_data_i,
  input wire logic rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req_o = '0;

  // one-cycle write pulse, then idle so repeat writes stay spaced
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be_n);
    @(posedge mclk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, be_n: be_n, wdata: d};
    @(posedge mclk_i);
    req_o <= '0;
    repeat (4) @(posedge mclk_i);
  endtask

  // one-cycle read pulse; answer sampled in the following cycle
  task automatic rd(input logic [11:0] a, input logic [3:0] be_n, output logic v, output logic [31:0] d);
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, be_n: be_n, wdata: 32'h0000_0000};
    @(posedge mclk_i);
    req_o <= '0;
    #1;
    v = rd_valid_i;
    d = rd_data_i;
  endtask
endmodule

/* test/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_valid;
  logic v;
  logic [31:0] rd_data, base, d;
  logic [15:0] idx [5] = '{16'h0001, 16'h1234, 16'h8000, 16'hfffe, 16'hffff};
  rxfq_pkg::rxfq_req_t req;
  rxfq_pkg::rxfq_addr_vec_t qaddr;
  int mismatches = 0;
  int compares = 0;

  rxfq_ptr_regs rxfq_ptr_regs_i (.mclk_i(mclk), .rst_n_i(rst_n), .req_i(req), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .queue_base_o(base), .queue_addr_o(qaddr));
  rxfq_host rxfq_host_i (.mclk_i(mclk), .req_o(req), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  initial forever #12.5 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  // expected address worked out here, independent of the design
  function automatic logic [31:0] phys(input logic [31:0] b, input logic [15:0] i);
    return b + {14'h0000, i, 2'b00};
  endfunction

  // reset leaves every pointer and address at zero
  task automatic t_reset;
    for (int k = 0; k < 5; k++) begin
      check("addr", 32'h0000_0000, qaddr[k]);
      rxfq_host_i.rd(rxfq_pkg::PTR_OFS[k], 4'h0, v, d);
      check("rd_valid", 32'h0000_0001, {31'h0000_0000, v});
      check("rd", 32'h0000_0000, d);
    end
  endtask

  // low half waits in the holding register for the high half
  task automatic t_base;
    rxfq_host_i.wr(rxfq_pkg::BASE_LO_OFS, 32'hffff_a5f0, 4'h0);
    check("base", 32'h0000_0000, base);
    rxfq_host_i.wr(rxfq_pkg::BASE_HI_OFS, 32'h0000_00c3, 4'h0);
    check("base", 32'h00c3_a5f0, base);
    rxfq_host_i.rd(rxfq_pkg::BASE_LO_OFS, 4'h0, v, d);
    check("base_lo_rd", 32'h0000_a5f0, d);
    rxfq_host_i.rd(rxfq_pkg::BASE_HI_OFS, 4'h0, v, d);
    check("base_hi_rd", 32'h0000_00c3, d);
  endtask

  // partial enables still write the whole index; upper half dropped
  task automatic t_ptrs;
    for (int k = 0; k < 5; k++) rxfq_host_i.wr(rxfq_pkg::PTR_OFS[k], {16'hffff, idx[k]}, 4'he);
    for (int k = 0; k < 5; k++) begin
      check("addr", phys(32'h00c3_a5f0, idx[k]), qaddr[k]);
      rxfq_host_i.rd(rxfq_pkg::PTR_OFS[k], 4'h0, v, d);
      check("rd", {16'h0000, idx[k]}, d);
    end
    // sum wraps at 32 bits with a high base and top index
    rxfq_host_i.wr(rxfq_pkg::BASE_HI_OFS, 32'h0000_ffff, 4'h0);
    check("wrap", phys(32'hffff_a5f0, 16'hffff), qaddr[4]);
  endtask

  // no enables means no access; unmapped read answers zero
  task automatic t_noen;
    rxfq_host_i.wr(rxfq_pkg::PTR_OFS[0], 32'h0000_5555, 4'hf);
    check("noen", phys(32'hffff_a5f0, idx[0]), qaddr[0]);
    rxfq_host_i.rd(rxfq_pkg::PTR_OFS[0], 4'hf, v, d);
    check("noen_valid", 32'h0000_0000, {31'h0000_0000, v});
    rxfq_host_i.rd(12'h298, 4'h0, v, d);
    check("unmap_valid", 32'h0000_0001, {31'h0000_0000, v});
    check("unmap", 32'h0000_0000, d);
  endtask

  // mid-run reset clears written pointers and base again
  task automatic t_rerun;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset;
  endtask

  task automatic summarize;
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset;
    t_base;
    t_ptrs;
    t_noen;
    t_rerun;
    summarize;
  end

  // whole run needs about 120 clocks
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    summarize;
  end
endmodule
